// File: tb/cre_core_properties.sv
// port checker of the cipher engine control block
`timescale 1ns/100ps
`default_nettype none

module cre_core_properties (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [5:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [15:0] sfr_wdata_i,
  input wire logic [15:0] sfr_rdata_o,
  input wire logic op_done_i,
  input wire logic key_wr_i,
  input wire logic [127:0] key_data_i,
  input wire logic otp_load_i,
  input wire logic [3:0] otp_page_i,
  input wire logic op_start_o,
  input wire logic [3:0] key_source_sel_o,
  input wire logic key_half_sel_o,
  input wire logic [255:0] key_store_o,
  input wire logic key_ram_erase_o,
  input wire logic rollover_o
);
  // ----------------------------------------------------------------
  // bus, key and counter relations
  // ----------------------------------------------------------------
  default clocking dcb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  a_rdata_idle_zero: assert property (!$past(sfr_rd_i) |-> sfr_rdata_o == 16'h0000)
    else $error("read data not zero without a read");
  a_key_read_zero: assert property (sfr_rd_i && sfr_addr_i[5:4] == 2'h2
    |=> sfr_rdata_o == 16'h0000)
    else $error("key word read returned data");
  a_hi_bit15_zero: assert property (sfr_rd_i && sfr_addr_i == 6'h00 |=> !sfr_rdata_o[15])
    else $error("control high bit 15 read as one");
  a_erase_one_pulse: assert property (sfr_wr_i && sfr_addr_i == 6'h00 && sfr_wdata_i[4]
    |=> key_ram_erase_o ##1 !key_ram_erase_o)
    else $error("erase request not a single pulse");
  // key half stays writable in a run, so only the source field is tied down here
  a_src_locked: assert property (op_start_o && !op_done_i && sfr_wr_i
    && sfr_addr_i == 6'h00 |=> key_source_sel_o == $past(key_source_sel_o))
    else $error("key source changed during a run");
  a_done_clears_start: assert property (op_start_o && op_done_i |=> !op_start_o)
    else $error("start bit not cleared after done");
  a_key_half_dest: assert property (key_wr_i && !otp_load_i && !sfr_wr_i
    && !key_ram_erase_o && key_half_sel_o |=> key_store_o[255:128] == $past(key_data_i))
    else $error("upper key half not loaded");
  a_otp_page_block: assert property (otp_load_i && otp_page_i == 4'h0 && !key_wr_i
    && !sfr_wr_i && !key_ram_erase_o |=> $stable(key_store_o))
    else $error("configuration page reached the key store");
  a_roll_after_done: assert property (rollover_o |-> $past(op_done_i) ##1 !rollover_o)
    else $error("rollover without completion or too long");
endmodule // cre_core_properties

`default_nettype wire

// File: tb/cre_dp_model.sv
// datapath stand-in: answers a running operation with a done pulse
`timescale 1ns/100ps
`default_nettype none

module cre_dp_model (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic busy_i,
  input wire logic [7:0] delay_i,
  output logic done_o
);
  // ----------------------------------------------------------------
  // completion timer, zero delay answers on the first cycle
  // ----------------------------------------------------------------
  logic [7:0] cnt;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !busy_i) begin
      cnt <= 8'h00;
      done_o <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      done_o <= (cnt == delay_i);
    end
  end
endmodule // cre_dp_model

`default_nettype wire

// File: tb/tb_cre_core.sv
// self-checking bench of the cipher engine control block
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("Error %s exp %0h got %0h", n, e, g); \
  end \
end

module tb_cre_core;
  logic mclk_i, rstn_i, module_power_off_i, sfr_wr_i, sfr_rd_i, op_done_i;
  logic dp_txta_we_i, dp_txtb_we_i, dp_txtc_we_i, key_wr_i, otp_load_i, wrap;
  logic enable_o, op_start_o, cipher_select_o, key_half_sel_o, key_ram_erase_o, rollover_o;
  logic [2:0] cipher_mode_o;
  logic [3:0] otp_page_i, op_mode_o, key_source_sel_o;
  logic [5:0] sfr_addr_i;
  logic [6:0] code;
  logic [7:0] dly;
  logic [15:0] sfr_wdata_i, sfr_rdata_o, d, w[24];
  logic [63:0] otp_prog_data_o;
  logic [127:0] dp_data_i, key_data_i, otp_data_i, text_a_o, text_b_o, text_c_o, v, mask;
  logic [255:0] key_store_o, km;
  cre_pkg::cre_keycfg_e key_cfg_o;
  integer seed = 32'hd818ca9c;
  int miscompares = 0, tests_run = 0, cycles = 0, roll_cnt = 0, r0;

  cre_core cre_core_inst (.*);
  cre_dp_model cre_dp_model_inst (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .busy_i(op_start_o),
    .delay_i(dly),
    .done_o(op_done_i)
  );

  // ----------------------------------------------------------------
  // clock, watchdog, helpers
  // ----------------------------------------------------------------
  always #4 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (rollover_o === 1'b1) roll_cnt <= roll_cnt + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] dat);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= dat;
    sfr_wr_i <= 1'b1;
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e, input string n);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge mclk_i);
    sfr_rd_i <= 1'b0;
    #1;
    `CHK(n, e, sfr_rdata_o)
  endtask

  task automatic go(input logic [15:0] hi, input logic [15:0] lo);
    wr(6'h00, hi);
    wr(6'h01, lo | 16'h8100);
  endtask

  // one extra edge so a rollover pulse after done is counted
  task automatic wait_idle();
    for (int k = 0; k < 300 && op_start_o !== 1'b0; k++) begin
      @(posedge mclk_i);
      #1;
    end
    `CHK("start bit", 1'b0, op_start_o)
    @(posedge mclk_i);
    #1;
  endtask

  task automatic rnd(output logic [127:0] r);
    for (int k = 0; k < 4; k++) r[32*k +: 32] = $random(seed);
  endtask

  function automatic logic [127:0] pk(input int b);
    logic [127:0] r;
    for (int k = 0; k < 8; k++) r[16*k +: 16] = w[b + k];
    return r;
  endfunction

  function automatic cre_pkg::cre_keycfg_e kcfg(input logic c, input logic [1:0] m);
    if (c) return (m == 2'h3) ? cre_pkg::CRE_KC_RSVD : cre_pkg::cre_keycfg_e'(3'h3 + m);
    if (m == 2'h2) return cre_pkg::CRE_KC_RSVD;
    return cre_pkg::cre_keycfg_e'((m == 2'h3) ? 3'h2 : {1'b0, m});
  endfunction

  initial begin
    mclk_i = 1'b0;
    rstn_i = 1'b0;
    {module_power_off_i, sfr_wr_i, sfr_rd_i, dp_txta_we_i, dp_txtb_we_i, dp_txtc_we_i} = '0;
    {key_wr_i, otp_load_i, otp_page_i, sfr_addr_i, sfr_wdata_i, dly} = '0;
    {dp_data_i, key_data_i, otp_data_i} = '0;
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(6'h00, 16'h0000, "control high");
    // erase first; the request only pulses key_ram_erase_o, the store stays as reset left it
    wr(6'h00, 16'h0010);
    `CHK("erase", 1'b1, key_ram_erase_o)
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      wr(6'h00, d & 16'hffef);
      rd(6'h00, d & 16'h7fef, "control high");
      `CHK("key source", d[3:0], key_source_sel_o)
    end
    for (int i = 0; i < 24; i++) begin
      w[i] = 16'($random(seed));
      wr(6'(8 + i), w[i]);
    end
    for (int i = 0; i < 24; i++) rd(6'(8 + i), w[i], "text word");
    `CHK("text a", pk(0), text_a_o)
    `CHK("text b", pk(8), text_b_o)
    `CHK("text c", pk(16), text_c_o)
    for (int k = 0; k < 16; k++) begin
      km[16*k +: 16] = 16'($random(seed));
      wr(6'(32 + k), km[16*k +: 16]);
    end
    `CHK("key store", km, key_store_o)
    rd(6'h25, 16'h0000, "key word");
    for (int j = 0; j < 5; j++) begin
      wr(6'h00, j[0] ? 16'h0080 : 16'h0000);
      rnd(v);
      @(posedge mclk_i);
      key_data_i <= v;
      otp_data_i <= v;
      otp_page_i <= j[2] ? 4'h0 : 4'h5;
      key_wr_i <= (j < 2);
      otp_load_i <= (j >= 2);
      @(posedge mclk_i);
      key_wr_i <= 1'b0;
      otp_load_i <= 1'b0;
      #1;
      if (j < 4 && j[0]) km[255:128] = v;
      if (j < 4 && !j[0]) km[127:0] = v;
      `CHK("key half", km, key_store_o)
    end
    dly = 8'h28;
    for (int j = 0; j < 8; j++) begin
      go({9'h000, j[1:0], 5'h00}, {8'h00, 4'h2, j[2], 3'h0});
      if (kcfg(j[2], j[1:0]) == cre_pkg::CRE_KC_RSVD) begin
        `CHK("start refused", 1'b0, op_start_o)
        rd(6'h02, 16'h0002, "status");
        wr(6'h02, 16'h00ff);
      end else begin
        `CHK("key config", kcfg(j[2], j[1:0]), key_cfg_o)
        `CHK("cipher select", j[2], cipher_select_o)
        `CHK("enable", 1'b1, enable_o)
        `CHK("op mode", 4'h2, op_mode_o)
        if (j == 0) begin
          wr(6'h08, ~w[0]);
          wr(6'h20, ~km[15:0]);
          wr(6'h00, 16'h000f);
          `CHK("text a", pk(0), text_a_o)
          `CHK("key store", km, key_store_o)
          `CHK("key source", 4'h0, key_source_sel_o)
        end
        wait_idle();
      end
    end
    for (int j = 0; j < 7; j++) begin
      code = (j < 2) ? 7'h00 : (j < 4) ? 7'h2a : 7'h7f;
      mask = (code == 7'h7f) ? '1 : (128'h1 << (code + 7'h01)) - 128'h1;
      rnd(v);
      v = j[0] ? (v & ~128'h1) : (v | mask);
      for (int i = 0; i < 8; i++) wr(6'(16 + i), v[16*i +: 16]);
      dly = j[0] ? 8'h00 : 8'h28;
      r0 = roll_cnt;
      go({1'b0, code, 8'h00}, {8'h00, 4'h2, 1'b1, (j < 6) ? 3'h4 : 3'h0});
      wait_idle();
      wrap = (j < 6) && !j[0];
      `CHK("counter", (j < 6) ? (v & ~mask) | ((v + 128'h1) & mask) : v, text_b_o)
      `CHK("rollover", int'(wrap), roll_cnt - r0)
      `CHK("cipher mode", (j < 6) ? 3'h4 : 3'h0, cipher_mode_o)
      rd(6'h02, {11'h000, wrap, 4'h0}, "status");
      wr(6'h02, 16'h00ff);
    end
    rnd(v);
    @(posedge mclk_i);
    dp_data_i <= v;
    dp_txtc_we_i <= 1'b1;
    @(posedge mclk_i);
    dp_txtc_we_i <= 1'b0;
    #1;
    `CHK("otp data", v[63:0], otp_prog_data_o)
    wr(6'h00, 16'h7faf);
    @(posedge mclk_i);
    module_power_off_i <= 1'b1;
    @(posedge mclk_i);
    module_power_off_i <= 1'b0;
    #1;
    `CHK("key half", 1'b0, key_half_sel_o)
    rd(6'h00, 16'h0000, "control high");
    end_sim();
  end
endmodule // tb_cre_core

bind cre_core cre_core_properties cre_core_properties_inst (.*);

`default_nettype wire

// File: verilog/cre_core.sv
// data arrays, key store and high control register of the cipher engine
// Functional notes
// - bus array and key writes ignored while running
// - each text array is one 128-bit element
// - wide arrays accessed as ordinary 16-bit words
// - text C holds result and OTP data
// - key store is write-only, reads zero
// - key store loaded by bus or OTP
// - text B counter, width code plus one
// - width code zero uses bit zero only
// - counter width only acts in CTR mode
// - key half select steers key destination
// - DES key mode decode, 10 reserved
// - AES key mode decode, 11 reserved
// - erase bit pulses, cleared next clock
// - 4-bit key source in bits 3:0
// - fields cleared on reset or power-off
// - config fields locked while running, except key half and erase
// - control high bit 15 reads zero
// - OTP configuration page never reachable
// - start bit cleared when operation completes
// - cipher select picks AES or DES
`timescale 1ns/100ps
`default_nettype none
`include "cre_regs.svh"

module cre_core (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic module_power_off_i,
  input wire logic [`CRE_AW-1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [`CRE_DW-1:0] sfr_wdata_i,
  output logic [`CRE_DW-1:0] sfr_rdata_o,
  input wire logic op_done_i,
  input wire logic dp_txta_we_i,
  input wire logic dp_txtb_we_i,
  input wire logic dp_txtc_we_i,
  input wire logic [127:0] dp_data_i,
  input wire logic key_wr_i,
  input wire logic [127:0] key_data_i,
  input wire logic otp_load_i,
  input wire logic [3:0] otp_page_i,
  input wire logic [127:0] otp_data_i,
  output logic enable_o,
  output logic op_start_o,
  output logic [3:0] op_mode_o,
  output logic cipher_select_o,
  output logic [2:0] cipher_mode_o,
  output logic [3:0] key_source_sel_o,
  output logic key_half_sel_o,
  output cre_pkg::cre_keycfg_e key_cfg_o,
  output logic [255:0] key_store_o,
  output logic [127:0] text_a_o,
  output logic [127:0] text_b_o,
  output logic [127:0] text_c_o,
  output logic [`CRE_OTP_DW-1:0] otp_prog_data_o,
  output logic key_ram_erase_o,
  output logic rollover_o
);

  cre_pkg::cre_state_s st;
  cre_pkg::cre_state_s next_st;
  cre_ctr_if cbus ();

  logic running;
  logic [2:0] rsel;
  logic [`CRE_TIDX_HI:0] tidx;
  logic [`CRE_KIDX_HI:0] kidx;
  logic wr_conh;
  logic wr_conl;
  logic wr_stat;
  logic wr_txta;
  logic wr_txtb;
  logic wr_txtc;
  logic wr_key;
  logic ctr_apply;
  logic go_req;
  logic cmode_bad;
  logic [15:0] conh_view;
  logic [15:0] conl_view;
  logic [15:0] stat_view;

  // ----------------------------------------------------------------------
  // counter stepper
  // ----------------------------------------------------------------------
  assign cbus.value = st.txt_b;
  assign cbus.width = st.ctr_w;

  cre_ctr u_ctr (
    .bus (cbus.ctr)
  );

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // each wide array is split into 16-bit word windows, so software sees
  // plain registers while storage stays one flop array
  always_comb begin
    running = (st.phase == cre_pkg::CRE_PH_RUN);
    rsel = sfr_addr_i[`CRE_REG_HI:`CRE_TSEL_LO];
    tidx = sfr_addr_i[`CRE_TIDX_HI:0];
    kidx = sfr_addr_i[`CRE_KIDX_HI:0];
    wr_conh = sfr_wr_i && (sfr_addr_i == `CRE_OFS_CONH);
    wr_conl = sfr_wr_i && (sfr_addr_i == `CRE_OFS_CONL);
    wr_stat = sfr_wr_i && (sfr_addr_i == `CRE_OFS_STAT);
    // data writes from the bus are dropped for the whole run
    wr_txta = sfr_wr_i && !running && (rsel == `CRE_SEL_TXTA);
    wr_txtb = sfr_wr_i && !running && (rsel == `CRE_SEL_TXTB);
    wr_txtc = sfr_wr_i && !running && (rsel == `CRE_SEL_TXTC);
    wr_key = sfr_wr_i && !running
      && (sfr_addr_i[`CRE_REG_HI:`CRE_KSEL_LO] == `CRE_SEL_KEY);
    go_req = wr_conl && sfr_wdata_i[`CRE_CONL_GO] && !running;
    cmode_bad = (sfr_wdata_i[`CRE_CONL_CMODE_HI:`CRE_CONL_CMODE_LO] > `CRE_CMODE_LAST);
    // counter steps only for CTR encrypt or decrypt runs
    ctr_apply = running && op_done_i
      && (st.cph_mode == `CRE_CMODE_CTR)
      && ((st.op_mode == `CRE_OPM_ENC) || (st.op_mode == `CRE_OPM_DEC));
  end

  // ----------------------------------------------------------------------
  // read views
  // ----------------------------------------------------------------------
  always_comb begin
    conh_view = '0;
    conh_view[`CRE_CONH_RSVD] = 1'b0;
    conh_view[`CRE_CONH_CTRW_HI:`CRE_CONH_CTRW_LO] = st.ctr_w;
    conh_view[`CRE_CONH_KHALF] = st.key_half;
    conh_view[`CRE_CONH_KMODE_HI:`CRE_CONH_KMODE_LO] = st.key_mode;
    conh_view[`CRE_CONH_ERASE] = st.erase;
    conh_view[`CRE_CONH_KSRC_HI:`CRE_CONH_KSRC_LO] = st.key_src;
    conl_view = '0;
    conl_view[`CRE_CONL_EN] = st.enable;
    conl_view[`CRE_CONL_GO] = running;
    conl_view[`CRE_CONL_OPM_HI:`CRE_CONL_OPM_LO] = st.op_mode;
    conl_view[`CRE_CONL_CSEL] = st.cph_sel;
    conl_view[`CRE_CONL_CMODE_HI:`CRE_CONL_CMODE_LO] = st.cph_mode;
    stat_view = '0;
    stat_view[`CRE_STAT_BUSY] = running;
    stat_view[`CRE_STAT_ABRT] = st.abort;
    stat_view[`CRE_STAT_ROLL] = st.roll_st;
    stat_view[`CRE_STAT_MODF] = st.mode_fail;
    stat_view[`CRE_STAT_KEYF] = st.key_fail;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.roll_pulse = 1'b0;
    // erase is a one-clock request; the bit never reads back as one for long
    next_st.erase = 1'b0;

    // control high: only key half and erase stay writable during a run
    if (wr_conh) begin
      next_st.key_half = sfr_wdata_i[`CRE_CONH_KHALF];
      next_st.erase = sfr_wdata_i[`CRE_CONH_ERASE];
      if (!running) begin
        next_st.ctr_w = sfr_wdata_i[`CRE_CONH_CTRW_HI:`CRE_CONH_CTRW_LO];
        next_st.key_mode = sfr_wdata_i[`CRE_CONH_KMODE_HI:`CRE_CONH_KMODE_LO];
        next_st.key_src = sfr_wdata_i[`CRE_CONH_KSRC_HI:`CRE_CONH_KSRC_LO];
      end
    end

    // control low: settings locked while running, start bit always visible
    if (wr_conl) begin
      if (!running) begin
        next_st.enable = sfr_wdata_i[`CRE_CONL_EN];
        next_st.op_mode = sfr_wdata_i[`CRE_CONL_OPM_HI:`CRE_CONL_OPM_LO];
        next_st.cph_sel = sfr_wdata_i[`CRE_CONL_CSEL];
        next_st.cph_mode = sfr_wdata_i[`CRE_CONL_CMODE_HI:`CRE_CONL_CMODE_LO];
      end else if (!sfr_wdata_i[`CRE_CONL_GO]) begin
        // software clearing the start bit stops the run
        next_st.phase = cre_pkg::CRE_PH_IDLE;
        next_st.abort = 1'b1;
      end
    end

    // key length decode follows the cipher selected on the bus
    case ({next_st.cph_sel, next_st.key_mode})
      {1'b0, `CRE_KM_0}: next_st.key_cfg = cre_pkg::CRE_KC_DES1;
      {1'b0, `CRE_KM_1}: next_st.key_cfg = cre_pkg::CRE_KC_TDES2;
      {1'b0, `CRE_KM_3}: next_st.key_cfg = cre_pkg::CRE_KC_TDES3;
      {1'b1, `CRE_KM_0}: next_st.key_cfg = cre_pkg::CRE_KC_AES128;
      {1'b1, `CRE_KM_1}: next_st.key_cfg = cre_pkg::CRE_KC_AES192;
      {1'b1, `CRE_KM_2}: next_st.key_cfg = cre_pkg::CRE_KC_AES256;
      default: next_st.key_cfg = cre_pkg::CRE_KC_RSVD;
    endcase

    // status: write one to clear; a same-cycle hardware set wins below
    if (wr_stat) begin
      if (sfr_wdata_i[`CRE_STAT_ABRT]) begin
        next_st.abort = 1'b0;
      end
      if (sfr_wdata_i[`CRE_STAT_ROLL]) begin
        next_st.roll_st = 1'b0;
      end
      if (sfr_wdata_i[`CRE_STAT_MODF]) begin
        next_st.mode_fail = 1'b0;
      end
      if (sfr_wdata_i[`CRE_STAT_KEYF]) begin
        next_st.key_fail = 1'b0;
      end
    end

    // run sequencing
    case (st.phase)
      cre_pkg::CRE_PH_IDLE: begin
        if (go_req && next_st.enable) begin
          if (next_st.key_cfg == cre_pkg::CRE_KC_RSVD) begin
            next_st.key_fail = 1'b1;
          end else if (cmode_bad) begin
            next_st.mode_fail = 1'b1;
          end else begin
            next_st.phase = cre_pkg::CRE_PH_RUN;
            next_st.abort = 1'b0;
          end
        end
      end
      cre_pkg::CRE_PH_RUN: begin
        if (op_done_i && next_st.phase == cre_pkg::CRE_PH_RUN) begin
          next_st.phase = cre_pkg::CRE_PH_IDLE;
        end
      end
      default: begin
        next_st.phase = cre_pkg::CRE_PH_IDLE;
      end
    endcase

    // text arrays: bus word writes when idle, datapath writes any time
    if (wr_txta) begin
      next_st.txt_a[tidx*16 +: 16] = sfr_wdata_i;
    end
    if (wr_txtb) begin
      next_st.txt_b[tidx*16 +: 16] = sfr_wdata_i;
    end
    if (wr_txtc) begin
      next_st.txt_c[tidx*16 +: 16] = sfr_wdata_i;
    end
    if (dp_txta_we_i) begin
      next_st.txt_a = dp_data_i;
    end
    if (dp_txtb_we_i) begin
      next_st.txt_b = dp_data_i;
    end
    if (dp_txtc_we_i) begin
      next_st.txt_c = dp_data_i;
    end

    // counter step overrides a datapath write to text B in the same cycle
    if (ctr_apply) begin
      next_st.txt_b = cbus.nxt;
      if (cbus.wrap) begin
        next_st.roll_st = 1'b1;
        next_st.roll_pulse = 1'b1;
      end
    end

    // key store: bus word writes, datapath keys and OTP transfers
    if (wr_key) begin
      next_st.key[kidx*16 +: 16] = sfr_wdata_i;
    end
    if (key_wr_i) begin
      if (st.key_half) begin
        next_st.key[255:128] = key_data_i;
      end else begin
        next_st.key[127:0] = key_data_i;
      end
    end
    // the configuration page is never copied into software-visible storage
    if (otp_load_i && (otp_page_i != `CRE_OTP_CFG_PAGE)) begin
      if (st.key_half) begin
        next_st.key[255:128] = otp_data_i;
      end else begin
        next_st.key[127:0] = otp_data_i;
      end
    end

    // registered read data; key words and unmapped words read zero
    next_st.rdata = `CRE_RDATA_ZERO;
    if (sfr_rd_i) begin
      if (sfr_addr_i == `CRE_OFS_CONH) begin
        next_st.rdata = conh_view;
      end else if (sfr_addr_i == `CRE_OFS_CONL) begin
        next_st.rdata = conl_view;
      end else if (sfr_addr_i == `CRE_OFS_STAT) begin
        next_st.rdata = stat_view;
      end else if (rsel == `CRE_SEL_TXTA) begin
        next_st.rdata = st.txt_a[tidx*16 +: 16];
      end else if (rsel == `CRE_SEL_TXTB) begin
        next_st.rdata = st.txt_b[tidx*16 +: 16];
      end else if (rsel == `CRE_SEL_TXTC) begin
        next_st.rdata = st.txt_c[tidx*16 +: 16];
      end else begin
        next_st.rdata = `CRE_RDATA_ZERO;
      end
    end

    // power-off drops all settings and data, like a reset
    if (module_power_off_i) begin
      next_st = '0;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // every output is a plain view of a state flop
  assign sfr_rdata_o = st.rdata;
  assign enable_o = st.enable;
  assign op_start_o = (st.phase == cre_pkg::CRE_PH_RUN);
  assign op_mode_o = st.op_mode;
  assign cipher_select_o = st.cph_sel;
  assign cipher_mode_o = st.cph_mode;
  assign key_source_sel_o = st.key_src;
  assign key_half_sel_o = st.key_half;
  assign key_cfg_o = st.key_cfg;
  // key goes only to the cipher datapath, never to the read mux
  assign key_store_o = st.key;
  assign text_a_o = st.txt_a;
  assign text_b_o = st.txt_b;
  assign text_c_o = st.txt_c;
  assign otp_prog_data_o = st.txt_c[`CRE_OTP_DW-1:0];
  assign key_ram_erase_o = st.erase;
  assign rollover_o = st.roll_pulse;

endmodule // cre_core

`default_nettype wire

// File: verilog/cre_ctr.sv
// counter stepper: increments the low width+1 bits of a 128-bit word
`timescale 1ns/100ps
`default_nettype none
`include "cre_regs.svh"

module cre_ctr (
  cre_ctr_if.ctr bus
);

  logic [127:0] mask;
  logic [127:0] inc;

  // ----------------------------------------------------------------------
  // step
  // ----------------------------------------------------------------------
  always_comb begin
    mask = {128{1'b1}} >> (`CRE_CTRW_MAX - bus.width);
    inc = ((bus.value & mask) + 128'h1) & mask;
    bus.nxt = (bus.value & ~mask) | inc;
    // a one-bit counter wraps exactly when bit zero falls from one to zero
    bus.wrap = (inc == '0);
  end

endmodule // cre_ctr

`default_nettype wire

// File: verilog/cre_ctr_if.sv
// counter request and answer between the control core and the counter stepper
`timescale 1ns/100ps
`default_nettype none

interface cre_ctr_if;
  logic [127:0] value;
  logic [6:0] width;
  logic [127:0] nxt;
  logic wrap;

  modport core (output value, output width, input nxt, input wrap);
  modport ctr (input value, input width, output nxt, output wrap);
endinterface // cre_ctr_if

`default_nettype wire

// File: verilog/cre_pkg.sv
// types shared by the cipher engine control block
package cre_pkg;

  typedef enum logic [2:0] {
    CRE_KC_DES1 = 3'b000,
    CRE_KC_TDES2 = 3'b001,
    CRE_KC_TDES3 = 3'b010,
    CRE_KC_AES128 = 3'b011,
    CRE_KC_AES192 = 3'b100,
    CRE_KC_AES256 = 3'b101,
    CRE_KC_RSVD = 3'b111
  } cre_keycfg_e;

  typedef enum logic {
    CRE_PH_IDLE = 1'b0,
    CRE_PH_RUN = 1'b1
  } cre_phase_e;

  typedef struct packed {
    logic [15:0] rdata;
    logic [6:0] ctr_w;
    logic key_half;
    logic [1:0] key_mode;
    logic erase;
    logic [3:0] key_src;
    logic enable;
    cre_phase_e phase;
    logic [3:0] op_mode;
    logic cph_sel;
    logic [2:0] cph_mode;
    logic abort;
    logic roll_st;
    logic roll_pulse;
    logic mode_fail;
    logic key_fail;
    cre_keycfg_e key_cfg;
    logic [127:0] txt_a;
    logic [127:0] txt_b;
    logic [127:0] txt_c;
    logic [255:0] key;
  } cre_state_s;

endpackage

// File: verilog/cre_regs.svh
// register offsets, field positions, codes and widths of the cipher engine control block
`ifndef CRE_REGS_SVH
`define CRE_REGS_SVH

// ----------------------------------------------------------------------
// register port geometry
// ----------------------------------------------------------------------
`define CRE_AW 6
`define CRE_DW 16
`define CRE_REG_HI 5
`define CRE_TSEL_LO 3
`define CRE_KSEL_LO 4
`define CRE_TIDX_HI 2
`define CRE_KIDX_HI 3

// ----------------------------------------------------------------------
// word offsets (16-bit words)
// ----------------------------------------------------------------------
`define CRE_OFS_CONH 6'h00
`define CRE_OFS_CONL 6'h01
`define CRE_OFS_STAT 6'h02
`define CRE_SEL_TXTA 3'h1
`define CRE_SEL_TXTB 3'h2
`define CRE_SEL_TXTC 3'h3
`define CRE_SEL_KEY 2'h2

// ----------------------------------------------------------------------
// engine_control_high fields
// ----------------------------------------------------------------------
`define CRE_CONH_RSVD 15
`define CRE_CONH_CTRW_HI 14
`define CRE_CONH_CTRW_LO 8
`define CRE_CONH_KHALF 7
`define CRE_CONH_KMODE_HI 6
`define CRE_CONH_KMODE_LO 5
`define CRE_CONH_ERASE 4
`define CRE_CONH_KSRC_HI 3
`define CRE_CONH_KSRC_LO 0

// ----------------------------------------------------------------------
// engine_control_low and status fields
// ----------------------------------------------------------------------
`define CRE_CONL_EN 15
`define CRE_CONL_GO 8
`define CRE_CONL_OPM_HI 7
`define CRE_CONL_OPM_LO 4
`define CRE_CONL_CSEL 3
`define CRE_CONL_CMODE_HI 2
`define CRE_CONL_CMODE_LO 0
`define CRE_STAT_BUSY 7
`define CRE_STAT_ABRT 5
`define CRE_STAT_ROLL 4
`define CRE_STAT_MODF 2
`define CRE_STAT_KEYF 1

// ----------------------------------------------------------------------
// codes and widths
// ----------------------------------------------------------------------
`define CRE_CMODE_CTR 3'h4
`define CRE_CMODE_LAST 3'h4
`define CRE_OPM_ENC 4'h2
`define CRE_OPM_DEC 4'h3
`define CRE_KM_0 2'h0
`define CRE_KM_1 2'h1
`define CRE_KM_2 2'h2
`define CRE_KM_3 2'h3
`define CRE_OTP_CFG_PAGE 4'h0
`define CRE_OTP_DW 64
`define CRE_CTRW_MAX 7'h7f
`define CRE_RDATA_ZERO 16'h0000

`endif
